// File: mbox_pkg.sv
// Shared constants and a helper function for the serial command mailbox
package mbox_pkg;
    localparam int DATA_W = 8;
    // Host I/O port map
    localparam logic [7:0] ADDR_CMD = 8'h01;
    localparam logic [7:0] ADDR_IRQ = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [7:0] ADDR_DATA = 8'h06;
    // Field positions
    localparam int CMD_POST_BIT = 1;
    localparam int CMD_POST_ALT_BIT = 0;
    localparam int STAT_OWNER_BIT = 0;
    localparam int STAT_OWNER_ALT_BIT = 2;
    localparam int IRQ_EN_BIT = 0;
    // Reset values
    localparam logic OWNER_RST = 1'b1;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] RESP_IDLE = 8'h00;
    localparam bit MSB_FIRST_DEF = 1'b1;
    // Timing of the sub-processor end
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCK_HALF_NS = 100;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
    localparam int FIFO_DEPTH = 16;

    // Position within a byte of serial bit number n
    function automatic logic [2:0] bit_index(input bit msb_first, input logic [2:0] n);
        bit_index = msb_first ? (3'd7 - n) : n;
    endfunction
endpackage

// File: mbox_link_if.sv
// Serial link between the mailbox and the sub-processor
`timescale 1ns/100ps
`default_nettype none
interface mbox_link_if;
    logic sck;
    logic frame;
    logic dev_sdo;
    logic sub_sdo;
    logic cmd_pending;
    logic done_tgl;
    logic sub_irq;

    modport dev (
        input sck,
        input frame,
        input sub_sdo,
        input done_tgl,
        input sub_irq,
        output dev_sdo,
        output cmd_pending
    );

    modport sub (
        output sck,
        output frame,
        output sub_sdo,
        output done_tgl,
        output sub_irq,
        input dev_sdo,
        input cmd_pending
    );
endinterface
`default_nettype wire

// File: mailbox_device.sv
// Host-facing mailbox: parallel I/O ports, serial shift register, ownership flip-flop
`timescale 1ns/100ps
`default_nettype none
module mailbox_device
    import mbox_pkg::*;
#(
    parameter bit MSB_FIRST = MSB_FIRST_DEF
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic host_irq_o,
    mbox_link_if.dev link
);

    // System clock domain state
    typedef struct packed {
        logic ownership_flipflop;
        logic cmd_pending;
        logic [7:0] data;
        logic sub_irq_enable;
        logic [7:0] rdata;
        logic host_irq;
        logic done_s1;
        logic done_s2;
        logic done_s3;
        logic irq_s1;
        logic irq_s2;
    } dev_t;

    // Link clock domain state
    typedef struct packed {
        logic [2:0] cnt;
        logic sdo;
    } shift_t;

    dev_t st;
    dev_t next_st;
    shift_t sh;
    shift_t next_sh;
    logic [7:0] rx_byte;
    logic [7:0] next_rx_byte;
    logic done_evt;
    logic post_cmd;
    logic wr_data;
    logic [7:0] status_byte;

    // ---------------- Link clock domain ----------------

    // The host byte is read here without a crossing: the host may only
    // change it while it owns the register, and the sub-processor only
    // clocks while the command is pending, so it is quiet during frames.
    always_comb begin
        next_sh = sh;
        next_sh.cnt = sh.cnt + 3'd1;
        next_sh.sdo = st.data[bit_index(MSB_FIRST, sh.cnt)];
    end

    // A frame's end clears the bit counter, since the link clock stops
    // between frames and cannot be relied on to finish any sequence.
    always_ff @(posedge link.sck or negedge link.frame) begin
        if (!link.frame) begin
            sh <= '0;
        end else begin
            sh <= next_sh;
        end
    end

    always_comb begin
        if (MSB_FIRST) begin
            next_rx_byte = {rx_byte[6:0], link.sub_sdo};
        end else begin
            next_rx_byte = {link.sub_sdo, rx_byte[7:1]};
        end
    end

    // Result byte holds after the frame; it is taken over by the system
    // domain only after the completion toggle has been synchronised.
    always_ff @(posedge link.sck) begin
        rx_byte <= next_rx_byte;
    end

    assign link.dev_sdo = sh.sdo;

    // ---------------- System clock domain ----------------

    assign done_evt = st.done_s2 ^ st.done_s3;
    assign wr_data = io_wr_i && (io_addr_i == ADDR_DATA);
    assign post_cmd = io_wr_i && (io_addr_i == ADDR_CMD) && st.ownership_flipflop &&
        (io_wdata_i[CMD_POST_BIT] || io_wdata_i[CMD_POST_ALT_BIT]);

    always_comb begin
        status_byte = 8'h00;
        status_byte[STAT_OWNER_BIT] = st.ownership_flipflop;
        status_byte[STAT_OWNER_ALT_BIT] = st.ownership_flipflop;
    end

    always_comb begin
        next_st = st;

        // Two-flop synchronisers; logic takes the second stage, plus done_s3 for the edge of done_tgl
        next_st.done_s1 = link.done_tgl;
        next_st.done_s2 = st.done_s1;
        next_st.done_s3 = st.done_s2;
        next_st.irq_s1 = link.sub_irq;
        next_st.irq_s2 = st.irq_s1;

        // Data writes are ignored while the sub-processor owns the register
        if (wr_data && st.ownership_flipflop) begin
            next_st.data = io_wdata_i;
        end

        if (io_wr_i && (io_addr_i == ADDR_IRQ)) begin
            next_st.sub_irq_enable = io_wdata_i[IRQ_EN_BIT];
        end

        if (post_cmd) begin
            next_st.ownership_flipflop = 1'b0;
        end

        // Completion wins over a command posted in the same cycle
        if (done_evt) begin
            next_st.ownership_flipflop = 1'b1;
            next_st.data = rx_byte;
        end

        next_st.cmd_pending = ~next_st.ownership_flipflop;

        next_st.host_irq = st.irq_s2 && st.sub_irq_enable;

        if (io_rd_i) begin
            unique case (io_addr_i)
                ADDR_DATA: begin
                    next_st.rdata = st.data;
                end
                ADDR_STATUS: begin
                    next_st.rdata = status_byte;
                end
                ADDR_IRQ: begin
                    next_st.rdata = {7'h00, st.irq_s2};
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '0;
            st.ownership_flipflop <= OWNER_RST;
            st.data <= DATA_RST;
        end else begin
            st <= next_st;
        end
    end

    assign io_rdata_o = st.rdata;
    assign host_irq_o = st.host_irq;
    assign link.cmd_pending = st.cmd_pending;

endmodule
`default_nettype wire

// File: mailbox_sub.sv
// Sub-processor end: makes the shift clock, swaps bytes, queues received commands
`timescale 1ns/100ps
`default_nettype none
module mbox_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

    // Flags and head word are registered so the outputs come from flops
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
        if (srst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            in_ready_o <= (next_wr_ptr[AW] == next_rd_ptr[AW]) ||
                (next_wr_ptr[AW-1:0] != next_rd_ptr[AW-1:0]);
            out_valid_o <= next_wr_ptr != next_rd_ptr;
            if (push && (next_rd_ptr == wr_ptr)) begin
                out_data_o <= in_data_i;
            end else begin
                out_data_o <= mem[next_rd_ptr[AW-1:0]];
            end
        end
    end
endmodule

module mailbox_sub
    import mbox_pkg::*;
#(
    parameter bit MSB_FIRST = MSB_FIRST_DEF
) (
    input wire logic clk_i,
    input wire logic srst_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_data_o,
    input wire logic cmd_ready_i,
    input wire logic res_valid_i,
    input wire logic [7:0] res_data_i,
    output logic res_ready_o,
    input wire logic irq_req_i,
    mbox_link_if.sub link
);
    typedef enum logic [2:0] {S_IDLE, S_START, S_LOW, S_HIGH, S_DONE, S_WAIT} sub_state_t;

    typedef struct packed {
        sub_state_t state;
        logic [DIV_W-1:0] div;
        logic [2:0] bitn;
        logic [7:0] tx;
        logic [7:0] rx;
        logic sck;
        logic frame;
        logic sdo;
        logic done_tgl;
        logic irq;
        logic pend_s1;
        logic pend_s2;
        logic din_s1;
        logic din_s2;
        logic res_rdy;
        logic push;
    } sub_t;

    sub_t st;
    sub_t next_st;
    logic fifo_in_ready;

    always_comb begin
        next_st = st;
        next_st.pend_s1 = link.cmd_pending;
        next_st.pend_s2 = st.pend_s1;
        next_st.din_s1 = link.dev_sdo;
        next_st.din_s2 = st.din_s1;
        next_st.irq = irq_req_i;
        next_st.push = 1'b0;
        next_st.res_rdy = 1'b0;
        next_st.div = st.div + 1'b1;
        unique case (st.state)
            S_IDLE: begin
                // No frame starts unless the queue can take its command
                if (st.pend_s2 && fifo_in_ready) begin
                    next_st.res_rdy = res_valid_i;
                    next_st.state = S_START;
                end
            end
            S_START: begin
                next_st.tx = st.res_rdy ? res_data_i : RESP_IDLE;
                next_st.frame = 1'b1;
                next_st.bitn = 3'd0;
                next_st.div = '0;
                next_st.state = S_LOW;
            end
            S_LOW: begin
                next_st.sck = 1'b0;
                next_st.sdo = st.tx[bit_index(MSB_FIRST, st.bitn)];
                if (st.div == DIV_LAST) begin
                    next_st.sck = 1'b1;
                    next_st.div = '0;
                    next_st.state = S_HIGH;
                end
            end
            S_HIGH: begin
                if (st.div == DIV_LAST) begin
                    next_st.sck = 1'b0;
                    next_st.div = '0;
                    next_st.rx[bit_index(MSB_FIRST, st.bitn)] = st.din_s2;
                    next_st.bitn = st.bitn + 3'd1;
                    next_st.state = (st.bitn == 3'd7) ? S_DONE : S_LOW;
                end
            end
            S_DONE: begin
                next_st.frame = 1'b0;
                next_st.push = 1'b1;
                next_st.done_tgl = ~st.done_tgl;
                next_st.state = S_WAIT;
            end
            S_WAIT: begin
                // Stale pending level must clear before another frame
                if (!st.pend_s2) begin
                    next_st.state = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '0;
            st.state <= S_IDLE;
        end else begin
            st <= next_st;
        end
    end

    mbox_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(st.push),
        .in_data_i(st.rx),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(cmd_valid_o),
        .out_data_o(cmd_data_o),
        .out_ready_i(cmd_ready_i)
    );

    assign res_ready_o = st.res_rdy;
    assign link.sck = st.sck;
    assign link.frame = st.frame;
    assign link.sub_sdo = st.sdo;
    assign link.done_tgl = st.done_tgl;
    assign link.sub_irq = st.irq;
endmodule
`default_nettype wire

// File: cpu_serial_mailbox_checker.sv
// Concurrent checks on the serial link between the two mailbox ends
`timescale 1ns/100ps
`default_nettype none
module cpu_serial_mailbox_checker (
    input wire logic dev_clk_i,
    input wire logic dev_srst_i,
    input wire logic sub_clk_i,
    input wire logic sub_srst_i,
    input wire logic sck,
    input wire logic frame,
    input wire logic dev_sdo,
    input wire logic sub_sdo,
    input wire logic cmd_pending,
    input wire logic done_tgl,
    input wire logic sub_irq
);
    logic [3:0] pulses;
    logic sck_d;
    // Counted in the sub domain, where sck is registered
    always_ff @(posedge sub_clk_i) begin
        sck_d <= sck;
        if (sub_srst_i || !frame) begin
            pulses <= 4'h0;
        end else if (sck && !sck_d) begin
            pulses <= pulses + 4'h1;
        end
    end
    property p_sck_idle;
        @(posedge sub_clk_i) disable iff (sub_srst_i) !frame |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("sck outside frame");
    property p_eight;
        @(posedge sub_clk_i) disable iff (sub_srst_i) $fell(frame) |-> pulses == 4'h8;
    endproperty
    a_eight: assert property (p_eight) else $error("pulse count");
    property p_done_end;
        @(posedge sub_clk_i) disable iff (sub_srst_i) $fell(frame) |-> $changed(done_tgl);
    endproperty
    a_done_end: assert property (p_done_end) else $error("no done at frame end");
    property p_done_only;
        @(posedge sub_clk_i) disable iff (sub_srst_i) $changed(done_tgl) |-> $fell(frame);
    endproperty
    a_done_only: assert property (p_done_only) else $error("stray done");
    property p_pend_frame;
        @(posedge sub_clk_i) disable iff (sub_srst_i) frame |-> cmd_pending;
    endproperty
    a_pend_frame: assert property (p_pend_frame) else $error("frame without pending");
    property p_pend_drop;
        @(posedge dev_clk_i) disable iff (dev_srst_i) $changed(done_tgl) |-> ##[1:8] !cmd_pending;
    endproperty
    a_pend_drop: assert property (p_pend_drop) else $error("pending not cleared");
    property p_sub_steady;
        @(posedge sub_clk_i) disable iff (sub_srst_i) sck && $past(sck) |-> $stable(sub_sdo);
    endproperty
    a_sub_steady: assert property (p_sub_steady) else $error("sub bit moved");
    property p_dev_rise;
        @(posedge sub_clk_i) disable iff (sub_srst_i) frame && $changed(dev_sdo) |-> sck;
    endproperty
    a_dev_rise: assert property (p_dev_rise) else $error("device bit off edge");
    c_irq: cover property (@(posedge dev_clk_i) $rose(sub_irq));
endmodule
`default_nettype wire

// File: cpu_serial_mailbox_bench.sv
// Bench joining both mailbox ends through the link interface
`timescale 1ns/100ps
`default_nettype none
module cpu_serial_mailbox_bench
    import mbox_pkg::*;
;
    logic clk_i = 1'b0;
    logic sub_clk = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] io_addr = 8'h00;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata, cmd_data, rd_val, exp_cmd, exp_res, dev_bits, sub_bits;
    logic host_irq, cmd_valid, res_ready;
    logic cmd_ready = 1'b0;
    logic res_valid = 1'b0;
    logic [7:0] res_data = 8'h00;
    logic irq_req = 1'b0;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int pulses = 0;
    int res_takes = 0;
    mbox_link_if link ();
    mailbox_device mailbox_device_i (.clk_i(clk_i), .srst_i(srst_i), .io_addr_i(io_addr),
        .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
        .host_irq_o(host_irq), .link(link.dev));
    mailbox_sub mailbox_sub_i (.clk_i(sub_clk), .srst_i(srst_i), .cmd_valid_o(cmd_valid),
        .cmd_data_o(cmd_data), .cmd_ready_i(cmd_ready), .res_valid_i(res_valid),
        .res_data_i(res_data), .res_ready_o(res_ready), .irq_req_i(irq_req), .link(link.sub));
    cpu_serial_mailbox_checker cpu_serial_mailbox_checker_i (.dev_clk_i(clk_i),
        .dev_srst_i(srst_i), .sub_clk_i(sub_clk), .sub_srst_i(srst_i), .sck(link.sck),
        .frame(link.frame), .dev_sdo(link.dev_sdo), .sub_sdo(link.sub_sdo),
        .cmd_pending(link.cmd_pending), .done_tgl(link.done_tgl), .sub_irq(link.sub_irq));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // Sub end runs on its own clock, offset so edges never line up
    initial begin
        #7.3;
        forever #12.5 sub_clk = ~sub_clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            final_report();
        end
    end
    always @(negedge sub_clk) begin
        if (res_ready === 1'b1) begin
            res_valid <= 1'b0;
            res_takes <= res_takes + 1;
        end
    end
    always @(posedge link.sck) begin
        sub_bits = {sub_bits[6:0], link.sub_sdo};
        pulses = pulses + 1;
    end
    always @(negedge link.sck) begin
        dev_bits = {dev_bits[6:0], link.dev_sdo};
    end
    always @(negedge link.frame) begin
        if (srst_i === 1'b0) begin
            check(8'(pulses), 8'h08);
            check(dev_bits, exp_cmd);
            check(sub_bits, exp_res);
        end
        pulses = 0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk_i);
        io_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_i);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk_i);
        io_rd = 1'b0;
        rd_val = io_rdata;
    endtask
    task automatic wait_ready();
        int n = 0;
        rd(ADDR_STATUS);
        while (rd_val !== 8'h05 && n < 300) begin
            rd(ADDR_STATUS);
            n++;
        end
        check(rd_val, 8'h05);
    endtask
    task automatic post(input logic [7:0] cmd, input logic [7:0] res, input logic [7:0] stb);
        @(negedge sub_clk);
        res_data = res;
        res_valid = 1'b1;
        exp_cmd = cmd;
        exp_res = res;
        rd(ADDR_STATUS);
        check(rd_val, 8'h05);
        wr(ADDR_DATA, cmd);
        wr(ADDR_CMD, stb);
        // Refused while owned by the sub end; a leak would corrupt the frame
        wr(ADDR_DATA, 8'hff);
        rd(ADDR_STATUS);
        check(rd_val, 8'h00);
    endtask
    task automatic pop(input logic [7:0] exp);
        int n = 0;
        repeat (2) @(negedge sub_clk);
        while (cmd_valid !== 1'b1 && n < 200) begin
            @(negedge sub_clk);
            n++;
        end
        check(cmd_data, exp);
        cmd_ready = 1'b1;
        @(negedge sub_clk);
        cmd_ready = 1'b0;
    endtask
    task automatic reset_values();
        rd(ADDR_STATUS);
        check(rd_val, 8'h05);
        rd(ADDR_DATA);
        check(rd_val, 8'h00);
        rd(8'h07);
        check(rd_val, 8'h00);
    endtask
    task automatic irq_scenario();
        @(negedge sub_clk);
        irq_req = 1'b1;
        repeat (10) @(negedge clk_i);
        check({7'h00, host_irq}, 8'h00);
        rd(ADDR_IRQ);
        check(rd_val, 8'h01);
        wr(ADDR_IRQ, 8'h01);
        repeat (4) @(negedge clk_i);
        check({7'h00, host_irq}, 8'h01);
        irq_req = 1'b0;
        repeat (10) @(negedge clk_i);
        check({7'h00, host_irq}, 8'h00);
        wr(ADDR_IRQ, 8'h00);
    endtask
    // Fill the command queue, stall on the full queue, then drain it
    task automatic fifo_scenario();
        for (int i = 0; i < 16; i++) begin
            post(8'h10 + 8'(i), 8'ha0 + 8'(i), i[0] ? 8'h01 : 8'h02);
            wait_ready();
            rd(ADDR_DATA);
            check(rd_val, 8'ha0 + 8'(i));
        end
        post(8'h3c, 8'hc3, 8'h02);
        repeat (400) @(negedge clk_i);
        rd(ADDR_STATUS);
        check(rd_val, 8'h00);
        for (int i = 0; i < 16; i++) begin
            pop(8'h10 + 8'(i));
        end
        wait_ready();
        rd(ADDR_DATA);
        check(rd_val, 8'hc3);
        pop(8'h3c);
        repeat (2) @(negedge sub_clk);
        // One result hand-over per frame, and the queue is drained
        check(8'(res_takes), 8'h11);
        check({7'h00, cmd_valid}, 8'h00);
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        srst_i = 1'b0;
        reset_values();
        irq_scenario();
        fifo_scenario();
        final_report();
    end
endmodule
`default_nettype wire
